// ### relay_channel_pkg.sv
// constants shared by the four-channel relay driver control logic
// assumes a 40 MHz mclk and a 16-bit serial frame from an external master
package relay_channel_pkg;
	localparam int CHANNELS = 4;
	localparam int FRAME_BITS = 16;
	localparam int MCLK_HZ = 40_000_000;
	// fail-safe restart wait, in microseconds
	localparam int FAIL_SAFE_RESTART_US = 1000;
	localparam int FAIL_SAFE_RESTART_CYCLES = (FAIL_SAFE_RESTART_US * (MCLK_HZ / 1_000_000));

	// register indices, shared by the serial port and the bus (byte address = index * 4)
	localparam logic [3:0] IDX_OUT_CTRL = 4'h0;
	localparam logic [3:0] IDX_MAP_A = 4'h1;
	localparam logic [3:0] IDX_MAP_B = 4'h2;
	localparam logic [3:0] IDX_OL_CURRENT = 4'h3;
	localparam logic [3:0] IDX_DIAG_OVL = 4'h4;
	localparam logic [3:0] IDX_DIAG_OT = 4'h5;
	localparam logic [3:0] IDX_MONITOR = 4'h6;
	localparam logic [3:0] IDX_IN_STATUS = 4'h7;
	localparam logic [3:0] IDX_HW_CTRL = 4'h8;

	// serial frame layout: write flag, register index, data byte
	localparam int FRM_WR_BIT = 15;
	localparam int FRM_IDX_HI = 11;
	localparam int FRM_IDX_LO = 8;
	localparam int FRM_DATA_HI = 7;
	localparam int HW_RST_BIT = 0;

	// values after reset
	localparam logic [3:0] OUT_CTRL_RESET = 4'h0;
	localparam logic [3:0] MAP_A_RESET = 4'h4;
	localparam logic [3:0] MAP_B_RESET = 4'h8;
	localparam logic [3:0] OL_CURRENT_RESET = 4'h0;

	// order of the bits in the synchronised input vector
	localparam int SY_IN_A = 0;
	localparam int SY_IN_B = 1;
	localparam int SY_IDLE = 2;
	localparam int SY_VDD = 3;
	localparam int SY_CSN = 4;
	localparam int SY_SCLK = 5;
	localparam int SY_SI = 6;
	localparam int SY_OVL = 7;
	localparam int SY_OT = 11;
	localparam int SY_OL = 15;
	localparam int SY_W = 19;
	// chip select idles high, everything else low
	localparam logic [SY_W-1:0] SYNC_RESET = 19'h00010;
endpackage

// ### relay_channel_control.sv
// serial control, input mapping, fail-safe mode and protection latches of a four-channel relay driver
// assumes all pins and analog detector flags are asynchronous to mclk; sclk is at most 5 MHz
`timescale 1ns/1ps

module relay_channel_control
	import relay_channel_pkg::*;
#(
	parameter int RESTART_CYCLES = FAIL_SAFE_RESTART_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// serial port
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// parallel and mode pins
	input wire logic parallel_input_a,
	input wire logic parallel_input_b,
	input wire logic idle,
	input wire logic vdd_present,
	// analog detector flags
	input wire logic [CHANNELS-1:0] overload_detect,
	input wire logic [CHANNELS-1:0] overtemp_detect,
	input wire logic [CHANNELS-1:0] open_load_detect,
	// power stage controls
	output logic [CHANNELS-1:0] channel_on,
	output logic [CHANNELS-1:0] open_load_test_current,
	output logic fail_safe_active
);
	logic rst_meta_q, rst_n;
	logic [SY_W-1:0] sy1_q, sy2_q;
	logic sclk_d1_q, cs_d1_q;
	logic [FRAME_BITS-1:0] shift_q;
	logic [4:0] bit_cnt_q;
	logic so_q;
	logic [3:0] reply_idx_q;
	logic [3:0] out_ctrl_q, map_a_q, map_b_q, ol_cur_q;
	logic [3:0] ovl_q, ot_q, mon_q, ch_on_q;
	logic ack_q;
	logic [31:0] rdata_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// every pin and detector flag passes two flops before use; the avalon inputs are used directly
	wire [SY_W-1:0] async_in = {open_load_detect, overtemp_detect, overload_detect, si, sclk, chip_select_n,
		vdd_present, idle, parallel_input_b, parallel_input_a};
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sy1_q <= SYNC_RESET;
			sy2_q <= SYNC_RESET;
		end else begin
			sy1_q <= async_in;
			sy2_q <= sy1_q;
		end
	end

	wire in_a = sy2_q[SY_IN_A];
	wire in_b = sy2_q[SY_IN_B];
	wire idle_s = sy2_q[SY_IDLE];
	wire vdd_s = sy2_q[SY_VDD];
	wire cs_s = sy2_q[SY_CSN];
	wire sclk_s = sy2_q[SY_SCLK];
	wire si_s = sy2_q[SY_SI];
	wire [3:0] ovl_s = sy2_q[SY_OVL +: CHANNELS];
	wire [3:0] ot_s = sy2_q[SY_OT +: CHANNELS];
	wire [3:0] ol_s = sy2_q[SY_OL +: CHANNELS];

	// fail-safe mode: idle low and no digital supply
	wire limp = ~idle_s & ~vdd_s;

	// serial edges, taken from the second and third stage only
	wire sclk_rise = sclk_s & ~sclk_d1_q;
	wire sclk_fall = ~sclk_s & sclk_d1_q;
	wire cs_fall = ~cs_s & cs_d1_q;
	wire cs_rise = cs_s & ~cs_d1_q;
	// a frame of any other length is dropped; so is anything without digital supply
	wire spi_done = cs_rise & (bit_cnt_q == 5'(FRAME_BITS)) & vdd_s;
	wire spi_we = spi_done & shift_q[FRM_WR_BIT];
	wire [3:0] spi_idx = shift_q[FRM_IDX_HI:FRM_IDX_LO];

	// avalon: one wait state, a serial write in the same cycle pushes the take back one cycle
	wire av_req = avs_read | avs_write;
	wire av_take = av_req & ack_q & ~spi_we;
	wire [3:0] av_idx = avs_address[5:2];
	wire av_hit = (av_idx <= IDX_HW_CTRL) & (avs_address[1:0] == 2'h0);
	assign avs_waitrequest = av_req & ~av_take;
	assign avs_readdata = rdata_q;

	// common write port
	wire wr_en = spi_we | (av_take & avs_write & av_hit);
	wire [3:0] wr_idx = spi_we ? spi_idx : av_idx;
	wire [7:0] wr_data = spi_we ? shift_q[FRM_DATA_HI:0] : avs_writedata[7:0];
	wire [3:0] wr_nib = wr_data[3:0];
	wire soft_rst = wr_en & (wr_idx == IDX_HW_CTRL) & wr_data[HW_RST_BIT];
	wire [3:0] clr_ovl = (wr_en & (wr_idx == IDX_DIAG_OVL)) ? wr_nib : 4'h0;
	wire [3:0] clr_ot = (wr_en & (wr_idx == IDX_DIAG_OT)) ? wr_nib : 4'h0;
	wire [3:0] clr_mon = (wr_en & (wr_idx == IDX_MONITOR)) ? wr_nib : 4'h0;

	function automatic logic [7:0] reg_view(input logic [3:0] idx);
		case (idx)
			IDX_OUT_CTRL: reg_view = {4'h0, out_ctrl_q};
			IDX_MAP_A: reg_view = {4'h0, map_a_q};
			IDX_MAP_B: reg_view = {4'h0, map_b_q};
			IDX_OL_CURRENT: reg_view = {4'h0, ol_cur_q};
			IDX_DIAG_OVL: reg_view = {4'h0, ovl_q};
			IDX_DIAG_OT: reg_view = {4'h0, ot_q};
			IDX_MONITOR: reg_view = {4'h0, mon_q};
			IDX_IN_STATUS: reg_view = {5'h00, limp, in_b, in_a};
			default: reg_view = 8'h00;
		endcase
	endfunction

	// reply frame holds the index asked for last and its contents
	wire [FRAME_BITS-1:0] reply = {4'h0, reply_idx_q, reg_view(reply_idx_q)};

	// one shift register carries both directions, so a longer chain simply passes bits on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d1_q <= 1'b0;
			cs_d1_q <= 1'b1;
			shift_q <= '0;
			bit_cnt_q <= 5'h00;
			so_q <= 1'b0;
			reply_idx_q <= 4'h0;
		end else begin
			sclk_d1_q <= sclk_s;
			cs_d1_q <= cs_s;
			if (cs_fall) begin
				shift_q <= reply;
				so_q <= reply[FRAME_BITS-1];
				bit_cnt_q <= 5'h00;
			end else if (!cs_s && sclk_rise) begin
				shift_q <= {shift_q[FRAME_BITS-2:0], si_s};
				bit_cnt_q <= (bit_cnt_q == 5'h1F) ? bit_cnt_q : bit_cnt_q + 5'h01;
			end else if (!cs_s && sclk_fall) begin
				so_q <= shift_q[FRAME_BITS-1];
			end
			if (spi_done) begin
				reply_idx_q <= spi_idx;
			end
		end
	end
	assign so = so_q;
	assign so_oe = ~cs_s;

	// channel requests
	wire [3:0] map_req = (map_a_q & {4{in_a}}) | (map_b_q & {4{in_b}});
	wire [3:0] normal_req = out_ctrl_q | map_req;
	wire [3:0] limp_req = {in_b, in_a, 2'b00};
	wire [3:0] req = limp ? limp_req : normal_req;
	wire [3:0] latched = ovl_q | ot_q;
	wire [3:0] retry_done;

	// fail-safe restart wait, one timer per channel
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_retry
			logic [31:0] cnt_q;
			wire waiting = ovl_q[g] & limp & req[g];
			assign retry_done[g] = waiting & (cnt_q == 32'(RESTART_CYCLES - 1));
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					cnt_q <= 32'h0;
				end else begin
					cnt_q <= (waiting && !retry_done[g]) ? cnt_q + 32'h1 : 32'h0;
				end
			end
		end
	endgenerate

	// configuration registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_ctrl_q <= OUT_CTRL_RESET;
			map_a_q <= MAP_A_RESET;
			map_b_q <= MAP_B_RESET;
			ol_cur_q <= OL_CURRENT_RESET;
		end else if (soft_rst) begin
			out_ctrl_q <= OUT_CTRL_RESET;
			map_a_q <= MAP_A_RESET;
			map_b_q <= MAP_B_RESET;
			ol_cur_q <= OL_CURRENT_RESET;
		end else if (wr_en) begin
			if (wr_idx == IDX_OUT_CTRL) out_ctrl_q <= wr_nib;
			if (wr_idx == IDX_MAP_A) map_a_q <= wr_nib;
			if (wr_idx == IDX_MAP_B) map_b_q <= wr_nib;
			if (wr_idx == IDX_OL_CURRENT) ol_cur_q <= wr_nib;
		end
	end

	// protection and diagnosis latches; a new event beats a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ovl_q <= 4'h0;
			ot_q <= 4'h0;
			mon_q <= 4'h0;
			ch_on_q <= 4'h0;
		end else begin
			ovl_q <= (ch_on_q & ovl_s) | (ovl_q & ~clr_ovl & ~retry_done);
			ot_q <= ot_s | (ot_q & ~clr_ot);
			mon_q <= (~ch_on_q & ol_s) | (mon_q & ~clr_mon);
			ch_on_q <= req & ~latched;
		end
	end
	assign channel_on = ch_on_q;
	assign open_load_test_current = ol_cur_q & ~ch_on_q;
	assign fail_safe_active = limp;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= av_req & ~av_take;
			if (av_req && !av_take) begin
				rdata_q <= av_hit ? {24'h000000, reg_view(av_idx)} : 32'h0;
			end
		end
	end

	// checks
	sequence s_ovl_hit;
		(ch_on_q & ovl_s) != 4'h0;
	endsequence
	sequence s_ovl_off;
		(ch_on_q & $past(ch_on_q & ovl_s, 2)) == 4'h0;
	endsequence

	chk_overload_latch: assert property (@(posedge mclk) disable iff (!rst_n)
		s_ovl_hit |=> ((ovl_q & $past(ch_on_q & ovl_s)) == $past(ch_on_q & ovl_s)) ##1 s_ovl_off)
		else $error("overloaded channel not latched off");
	chk_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(latched != 4'h0) |=> ((ch_on_q & $past(latched)) == 4'h0))
		else $error("latched channel switched on");
	chk_limp_route: assert property (@(posedge mclk) disable iff (!rst_n)
		(limp && latched == 4'h0) |=> (ch_on_q == {$past(in_b), $past(in_a), 2'b00}))
		else $error("fail-safe routing wrong");
	chk_normal_or: assert property (@(posedge mclk) disable iff (!rst_n)
		(!limp && latched == 4'h0) |=> (ch_on_q == $past(out_ctrl_q | map_req)))
		else $error("channel request is not the or of control and inputs");
	chk_supply_gate: assert property (@(posedge mclk) disable iff (!rst_n)
		(!vdd_s && !avs_write) |=> ($stable(out_ctrl_q) && $stable(map_a_q) &&
		$stable(map_b_q) && $stable(ol_cur_q)))
		else $error("configuration changed without digital supply");
	chk_frame_len: assert property (@(posedge mclk) disable iff (!rst_n)
		spi_done |-> (bit_cnt_q == 5'h10 && $rose(cs_s)))
		else $error("frame accepted with wrong length");
	chk_so_release: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(chip_select_n, 2) |-> !so_oe)
		else $error("serial output driven while deselected");
	chk_default_map: assert property (@(posedge mclk)
		$rose(rst_n) |-> (map_a_q == 4'h4 && map_b_q == 4'h8))
		else $error("default input mapping wrong after reset");
	chk_retry_release: assert property (@(posedge mclk) disable iff (!rst_n)
		(retry_done != 4'h0 && clr_ovl == 4'h0) |=> ((ovl_q & $past(retry_done)) == 4'h0))
		else $error("fail-safe retry did not clear overload latch");
	chk_monitor_keep: assert property (@(posedge mclk) disable iff (!rst_n)
		(mon_q != 4'h0 && clr_mon == 4'h0) |=> ((mon_q & $past(mon_q)) == $past(mon_q)))
		else $error("monitor bit lost without a clear");
	chk_ot_latch: assert property (@(posedge mclk) disable iff (!rst_n)
		(ot_s != 4'h0) |=> ((ot_q & $past(ot_s)) == $past(ot_s)) ##1 ((ch_on_q & $past(ot_s, 2)) == 4'h0))
		else $error("over-temperature channel not latched off");
endmodule

// ### spi_master_model.sv
// microcontroller model acting as serial master for the relay driver
// assumes mode 0 framing and a 40 MHz mclk; sclk runs only inside frames
`timescale 1ns/1ps
module spi_master_model (
	// clock
	input wire logic mclk,
	// serial lines
	output logic chip_select_n,
	output logic sclk,
	output logic si,
	input wire logic so
);
	initial begin
		chip_select_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// n bits msb first; 4 mclk per half period gives a 200 ns sclk
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		@(posedge mclk);
		chip_select_n <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = n - 1; i >= 0; i--) begin
			si <= tx[i];
			repeat (4) @(posedge mclk);
			sclk <= 1'b1;
			rx = {rx[30:0], so};
			repeat (4) @(posedge mclk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		chip_select_n <= 1'b1;
		// si falls to its pull-down level once released
		si <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ### relay_channel_control_test.sv
// self-checking bench for the relay driver control logic
// assumes the serial master model beside it and a shortened restart time
`timescale 1ns/1ps
module relay_channel_control_test;
	import relay_channel_pkg::*;
	localparam int RESTART = 20;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic chip_select_n, sclk, si, so, so_oe;
	// a released output floats; show the inverse so a late enable is caught
	wire so_line = so_oe ? so : ~so;
	logic parallel_input_a = 1'b0;
	logic parallel_input_b = 1'b0;
	logic idle = 1'b1;
	logic vdd_present = 1'b1;
	logic [3:0] overload_detect = 4'h0;
	logic [3:0] overtemp_detect = 4'h0;
	logic [3:0] open_load_detect = 4'h0;
	logic [3:0] channel_on, open_load_test_current;
	logic fail_safe_active;
	logic [31:0] rx;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;

	always #12.5 mclk = ~mclk;

	relay_channel_control #(.RESTART_CYCLES(RESTART)) uut (.mclk(mclk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .chip_select_n(chip_select_n), .sclk(sclk), .si(si), .so(so),
		.so_oe(so_oe), .parallel_input_a(parallel_input_a), .parallel_input_b(parallel_input_b), .idle(idle),
		.vdd_present(vdd_present), .overload_detect(overload_detect), .overtemp_detect(overtemp_detect),
		.open_load_detect(open_load_detect), .channel_on(channel_on),
		.open_load_test_current(open_load_test_current), .fail_safe_active(fail_safe_active));

	spi_master_model master (.mclk(mclk), .chip_select_n(chip_select_n), .sclk(sclk), .si(si), .so(so_line));

	task print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus_rd(input logic [5:0] a, input logic [31:0] exp, input string name);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		check(name, avs_readdata, exp);
		avs_read <= 1'b0;
	endtask

	task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic frame(input logic [15:0] f);
		master.xfer(16, {16'h0, f}, rx);
	endtask

	// inputs cross two synchronisers and a register before reaching channel_on
	task automatic settle;
		repeat (8) @(posedge mclk);
	endtask

	// a hang ends the run here; the sequence needs well under this many cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			print_verdict;
		end
	end

	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		repeat (6) @(posedge mclk);
		bus_rd(6'h00, 32'h0, "out_ctrl reset");
		bus_rd(6'h04, 32'h4, "map_a reset");
		bus_rd(6'h08, 32'h8, "map_b reset");
		bus_rd(6'h24, 32'h0, "unmapped read");
		check("so_oe idle", so_oe, 1'b0);
		@(posedge mclk);
		parallel_input_a <= 1'b1;
		parallel_input_b <= 1'b1;
		settle;
		check("default map", channel_on, 4'hC);
		@(posedge mclk);
		parallel_input_b <= 1'b0;
		frame(16'h8103);
		frame(16'h0000);
		check("reply", rx[15:0], 16'h0103);
		check("so_oe after frame", so_oe, 1'b0);
		check("mapped pin", channel_on, 4'h3);
		bus_wr(6'h00, 32'h8);
		settle;
		check("ctrl or map", channel_on, 4'hB);
		master.xfer(32, 32'h80F1_0000, rx);
		check("chain pass", rx[15:0], 16'h80F1);
		@(posedge mclk);
		vdd_present <= 1'b0;
		settle;
		frame(16'h800F);
		@(posedge mclk);
		vdd_present <= 1'b1;
		bus_rd(6'h00, 32'h8, "ignored frames");
		@(posedge mclk);
		parallel_input_a <= 1'b0;
		settle;
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			{overtemp_detect, overload_detect} <= (k == 0) ? 8'h08 : 8'h80;
			settle;
			check("trip off", channel_on, 4'h0);
			@(posedge mclk);
			{overtemp_detect, overload_detect} <= 8'h00;
			settle;
			check("latched off", channel_on, 4'h0);
			bus_rd((k == 0) ? 6'h10 : 6'h14, 32'h8, "diag latch");
			frame((k == 0) ? 16'h8408 : 16'h8508);
			settle;
			check("re-enabled", channel_on, 4'h8);
		end
		bus_wr(6'h00, 32'h0);
		frame(16'h8302);
		settle;
		check("test current", open_load_test_current, 4'h2);
		@(posedge mclk);
		open_load_detect <= 4'h2;
		settle;
		@(posedge mclk);
		open_load_detect <= 4'h0;
		settle;
		bus_rd(6'h18, 32'h2, "open load monitor");
		@(posedge mclk);
		idle <= 1'b0;
		vdd_present <= 1'b0;
		parallel_input_a <= 1'b1;
		settle;
		check("fail safe", fail_safe_active, 1'b1);
		check("fail safe route", channel_on, 4'h4);
		bus_rd(6'h1C, 32'h5, "input status");
		@(posedge mclk);
		overload_detect <= 4'h4;
		settle;
		check("limp trip", channel_on, 4'h0);
		@(posedge mclk);
		overload_detect <= 4'h0;
		repeat (3) @(posedge mclk);
		check("limp wait", channel_on, 4'h0);
		repeat (RESTART + 20) @(posedge mclk);
		check("limp retry", channel_on, 4'h4);
		bus_wr(6'h20, 32'h1);
		bus_rd(6'h04, 32'h4, "soft reset map_a");
		bus_rd(6'h0C, 32'h0, "soft reset test current");
		print_verdict;
	end
endmodule
